// ### core/srp_target.sv
// Serial target end: decodes start/stop, address, register pointer, data.
// Assumes the link clock oversamples SCL; register array sits outside on it.
`timescale 1ns/1ns
module srp_target #(
  parameter int POWERUP_CYC = srp_pkg::SRP_POWERUP_CYC,
  parameter int WRCYC_CYC   = srp_pkg::SRP_WRCYC_CYC
) (
  input  wire logic              link_clk_i,
  input  wire logic              nrst_i,
  srp_i2c_if.target              bus,
  output srp_pkg::srp_byte_t     reg_ptr_o,
  input  wire srp_pkg::srp_byte_t reg_rdata_i,
  output logic                   reg_we_o,
  output srp_pkg::srp_byte_t     reg_waddr_o,
  output srp_pkg::srp_byte_t     reg_wdata_o,
  output logic                   busy_o
);
  import srp_pkg::*;

  typedef enum logic [3:0] {
    ST_PWRUP, ST_IDLE, ST_DEV, ST_DEV_ACK, ST_REG, ST_REG_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_BUSY
  } srp_tstate_t;

  srp_tstate_t state_q, state_d;
  logic [3:0]  cnt_q, cnt_d;
  srp_byte_t   sh_q, sh_d;
  srp_byte_t   tx_q, tx_d;
  srp_byte_t   ptr_q, ptr_d;
  srp_byte_t   pend_q, pend_d;
  logic        pend_v_q, pend_v_d;
  logic        rw_q, rw_d;
  logic        sda_low_q, sda_low_d;
  logic        we_q, we_d;
  srp_byte_t   waddr_q, waddr_d;
  srp_byte_t   wdata_q, wdata_d;
  logic [15:0] tmr_q, tmr_d;
  logic        scl_s, sda_s, scl_p, sda_p;

  // ---------------------------------------------------------------
  // Line sampling and bus events
  // ---------------------------------------------------------------
  srp_sync2 #(.RESET_VAL(1'b1)) u_scl (
    .clk_i (link_clk_i), .nrst_i (nrst_i), .d_i (bus.scl), .q_o (scl_s)
  );
  srp_sync2 #(.RESET_VAL(1'b1)) u_sda (
    .clk_i (link_clk_i), .nrst_i (nrst_i), .d_i (bus.sda), .q_o (sda_s)
  );

  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;
  wire start_ev = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_ev  = scl_s & scl_p & ~sda_p & sda_s;
  wire byte_end = scl_fall & (cnt_q == SRP_BYTE_BITS);
  wire locked   = (state_q == ST_PWRUP) || (state_q == ST_BUSY);
  wire shifting = (state_q == ST_DEV) || (state_q == ST_REG) || (state_q == ST_WR);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    tx_d     = tx_q;
    ptr_d    = ptr_q;
    pend_d   = pend_q;
    pend_v_d = pend_v_q;
    rw_d     = rw_q;
    sda_low_d = sda_low_q;
    we_d     = 1'b0;
    waddr_d  = waddr_q;
    wdata_d  = wdata_q;
    tmr_d    = tmr_q;
    // [R1] Shift in MSB first
    if (shifting && scl_rise) begin
      sh_d  = {sh_q[6:0], sda_s};
      cnt_d = cnt_q + 4'h1;
    end
    case (state_q)
      ST_PWRUP, ST_BUSY: begin
        // [R4] Power-up hold-off
        // [R13] Inputs ignored, line released
        sda_low_d = 1'b0;
        if (tmr_q == 16'h0000) state_d = ST_IDLE;
        else tmr_d = tmr_q - 16'h0001;
      end
      ST_DEV: begin
        if (byte_end) begin
          // [R11] Address match then ack
          if (sh_q[7:1] == SRP_DEV_ID) begin
            sda_low_d = 1'b1;
            rw_d      = sh_q[0];
            state_d   = ST_DEV_ACK;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_DEV_ACK: begin
        if (scl_fall) begin
          cnt_d = 4'h0;
          if (rw_q == SRP_DIR_RD) begin
            // [R16] First read byte loaded
            tx_d      = reg_rdata_i;
            sda_low_d = ~reg_rdata_i[7];
            state_d   = ST_RD;
          end else begin
            sda_low_d = 1'b0;
            state_d   = ST_REG;
          end
        end
      end
      ST_REG: begin
        // [R8] Ack register byte
        if (byte_end) begin
          sda_low_d = 1'b1;
          state_d   = ST_REG_ACK;
        end
      end
      ST_REG_ACK: begin
        if (scl_fall) begin
          sda_low_d = 1'b0;
          ptr_d     = sh_q;
          cnt_d     = 4'h0;
          state_d   = ST_WR;
        end
      end
      ST_WR: begin
        // [R9] Ack every data byte
        if (byte_end) begin
          sda_low_d = 1'b1;
          state_d   = ST_WR_ACK;
        end
      end
      ST_WR_ACK: begin
        if (scl_fall) begin
          // [R14] Commit previous, advance pointer
          if (pend_v_q) begin
            we_d    = 1'b1;
            waddr_d = ptr_q;
            wdata_d = pend_q;
            ptr_d   = srp_next_ptr(ptr_q);
          end
          pend_d    = sh_q;
          pend_v_d  = 1'b1;
          sda_low_d = 1'b0;
          cnt_d     = 4'h0;
          state_d   = ST_WR;
        end
      end
      ST_RD: begin
        if (scl_rise) cnt_d = cnt_q + 4'h1;
        // [R23] Drive changes on falling clock
        if (scl_fall) begin
          if (cnt_q == SRP_BYTE_BITS) begin
            // [R7] Release for host ack
            sda_low_d = 1'b0;
            state_d   = ST_RD_ACK;
          end else begin
            sda_low_d = ~tx_q[6];
            tx_d      = {tx_q[6:0], 1'b0};
          end
        end
      end
      ST_RD_ACK: begin
        if (scl_rise) begin
          // [R22] Advance after transmitted byte
          ptr_d = srp_next_ptr(ptr_q);
          sh_d  = {sh_q[7:1], sda_s};
        end
        if (scl_fall) begin
          // [R18] Continue only on host ack
          if (!sh_q[0]) begin
            tx_d      = reg_rdata_i;
            sda_low_d = ~reg_rdata_i[7];
            cnt_d     = 4'h0;
            state_d   = ST_RD;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      default: ;
    endcase
    // [R3] Start restarts decoding in any state except power-up and busy
    if (!locked && start_ev) begin
      state_d   = ST_DEV;
      cnt_d     = 4'h0;
      pend_v_d  = 1'b0;
      sda_low_d = 1'b0;
    end else if (!locked && stop_ev) begin
      sda_low_d = 1'b0;
      pend_v_d  = 1'b0;
      // [R12] Commit last byte after stop
      // The stop's own clock rise has already counted one bit
      if (state_q == ST_WR && cnt_q == 4'h1 && pend_v_q) begin
        we_d    = 1'b1;
        waddr_d = ptr_q;
        wdata_d = pend_q;
        tmr_d   = 16'(WRCYC_CYC);
        state_d = ST_BUSY;
      end else begin
        // [R5] Stop returns to standby
        // [R6] Partial byte discarded
        state_d = ST_IDLE;
      end
    end
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_PWRUP;
      tmr_q   <= 16'(POWERUP_CYC);
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      tx_q    <= 8'h00;
      ptr_q   <= SRP_REG_FIRST;
      pend_q  <= 8'h00;
      pend_v_q <= 1'b0;
      rw_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      tmr_q   <= tmr_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      tx_q    <= tx_d;
      ptr_q   <= ptr_d;
      pend_q  <= pend_d;
      pend_v_q <= pend_v_d;
      rw_q    <= rw_d;
    end
  end

  always_ff @(posedge link_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_p     <= 1'b1;
      sda_p     <= 1'b1;
      sda_low_q <= 1'b0;
      we_q      <= 1'b0;
      waddr_q   <= 8'h00;
      wdata_q   <= 8'h00;
    end else begin
      scl_p     <= scl_s;
      sda_p     <= sda_s;
      sda_low_q <= sda_low_d;
      we_q      <= we_d;
      waddr_q   <= waddr_d;
      wdata_q   <= wdata_d;
    end
  end

  // [R20] Open-drain drive of SDA
  assign bus.sda_t_o    = 1'b0;
  assign bus.sda_t_oe_n = ~sda_low_q;
  assign reg_ptr_o      = ptr_q;
  assign reg_we_o       = we_q;
  assign reg_waddr_o    = waddr_q;
  assign reg_wdata_o    = wdata_q;
  assign busy_o         = locked;
endmodule : srp_target

// ### core/srp_pkg.sv
// Shared constants and types for the sensor register port serial link.
// Assumes a host end on ref_clk_i and a target end on the link clock.
//
// What the document requires
// [R1] Bytes travel most significant bit first
// [R2] Data changes only while clock low
// [R3] Target watches for start, ignores before it
// [R4] Starts during power-up are ignored
// [R5] Stop after complete transfer returns idle
// [R6] Early stop abandons transfer, no writes
// [R7] Transmitter releases, receiver acks ninth pulse
// [R8] Target acks address and register bytes
// [R9] Target acks every written data byte
// [R10] Host acks read bytes to continue
// [R11] Address 1000100 plus direction bit matches
// [R12] Single write commits data after stop
// [R13] Target ignores bus during write cycle
// [R14] Burst write acks and advances pointer
// [R15] Pointer wraps, keeps last written address
// [R16] Read: write address, restart, read byte
// [R17] Host ends read with nack, stop
// [R18] Target sends bytes while host acks
// [R19] Host starts only on idle bus
// [R20] Drive low for zero, release for one
// [R21] Host writes zero to reserved bits; host passes data unchanged, caller zeroes them
// [R22] Pointer advances after each read byte
// [R23] Target changes data only clock low
package srp_pkg;

  typedef logic [7:0] srp_byte_t;

  // ---------------------------------------------------------------
  // Addressing
  // ---------------------------------------------------------------
  localparam logic [6:0] SRP_DEV_ID    = 7'h44;
  localparam srp_byte_t  SRP_REG_FIRST = 8'h00;
  localparam srp_byte_t  SRP_REG_LAST  = 8'h0A;
  localparam logic [3:0] SRP_BYTE_BITS = 4'h8;
  localparam logic       SRP_DIR_WR    = 1'h0;
  localparam logic       SRP_DIR_RD    = 1'h1;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SRP_REF_PERIOD_NS  = 10;
  localparam int SRP_LINK_PERIOD_NS = 30;
  localparam int SRP_POWERUP_NS     = 100000;
  localparam int SRP_WRCYC_NS       = 1000;
  localparam int SRP_SCL_PERIOD_NS  = 2500;
  localparam int SRP_POWERUP_CYC    =
    (SRP_POWERUP_NS + SRP_LINK_PERIOD_NS - 1) / SRP_LINK_PERIOD_NS;
  localparam int SRP_WRCYC_CYC      =
    (SRP_WRCYC_NS + SRP_LINK_PERIOD_NS - 1) / SRP_LINK_PERIOD_NS;
  localparam int SRP_QTR_CYC        = SRP_SCL_PERIOD_NS / (4 * SRP_REF_PERIOD_NS);

  // [R15] Wrap past last register
  function automatic srp_byte_t srp_next_ptr(input srp_byte_t p);
    srp_next_ptr = (p == SRP_REG_LAST) ? SRP_REG_FIRST : srp_byte_t'(p + 8'h01);
  endfunction : srp_next_ptr

endpackage : srp_pkg

// ### core/srp_i2c_if.sv
// Two-wire link between host and target ends.
// Assumes pull-ups: a line is high unless some end enables its low drive.
`timescale 1ns/1ns
interface srp_i2c_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic sda_t_o;
  logic sda_t_oe_n;
  logic scl;
  logic sda;

  // ---------------------------------------------------------------
  // Wired-AND line levels
  // ---------------------------------------------------------------
  assign scl = scl_oe_n | scl_o;
  assign sda = (sda_h_oe_n | sda_h_o) & (sda_t_oe_n | sda_t_o);

  modport host   (output scl_o, scl_oe_n, sda_h_o, sda_h_oe_n, input scl, sda);
  modport target (output sda_t_o, sda_t_oe_n, input scl, sda);
endinterface : srp_i2c_if

// ### core/srp_sync2.sv
// Two-flop synchroniser for a pin level.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ns
module srp_sync2 #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= RESET_VAL;
      q_o    <= RESET_VAL;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : srp_sync2

// ### core/srp_host.sv
// Host end: runs single-byte register writes and reads over the link.
// Assumes pull-ups on the lines and no clock stretching by the target.
`timescale 1ns/1ns
module srp_host #(
  parameter int QTR_CYC = srp_pkg::SRP_QTR_CYC
) (
  input  wire logic               ref_clk_i,
  input  wire logic               nrst_i,
  srp_i2c_if.host                 bus,
  input  wire logic               cmd_valid_i,
  output logic                    cmd_ready_o,
  input  wire logic               cmd_read_i,
  input  wire srp_pkg::srp_byte_t cmd_reg_i,
  input  wire srp_pkg::srp_byte_t cmd_wdata_i,
  output logic                    done_o,
  output logic                    nack_o,
  output srp_pkg::srp_byte_t      rdata_o
);
  import srp_pkg::*;

  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} srp_hstate_t;

  srp_hstate_t st_q;
  logic [15:0] div_q;
  logic [1:0]  qtr_q;
  logic [3:0]  bit_q;
  logic [1:0]  idx_q;
  logic        rd_q, scl_low_q, sda_low_q, nack_q, done_q;
  srp_byte_t   reg_q, wd_q, sh_q, rdata_q;
  logic        sda_s;

  srp_sync2 #(.RESET_VAL(1'b1)) u_sda (
    .clk_i (ref_clk_i), .nrst_i (nrst_i), .d_i (bus.sda), .q_o (sda_s)
  );

  // ---------------------------------------------------------------
  // Byte selection
  // ---------------------------------------------------------------
  wire tick      = (div_q == 16'h0000);
  wire rx_mode   = rd_q && (idx_q == 2'h3);
  wire last_byte = rd_q ? (idx_q == 2'h3) : (idx_q == 2'h2);
  wire bit_data  = (bit_q < SRP_BYTE_BITS);
  // [R21] Data passed through unchanged; caller zeroes reserved bits
  wire srp_byte_t cur_byte = (idx_q == 2'h0) ? {SRP_DEV_ID, SRP_DIR_WR} :
                             (idx_q == 2'h1) ? reg_q :
                             rd_q            ? {SRP_DEV_ID, SRP_DIR_RD} : wd_q;
  // [R1] MSB first
  wire tx_bit = cur_byte[~bit_q[2:0]];
  // [R19] Start only on idle bus
  assign cmd_ready_o = (st_q == M_IDLE) && sda_s;

  // ---------------------------------------------------------------
  // Bit sequencer, four quarters per bit
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= M_IDLE; div_q <= 16'h0000; qtr_q <= 2'h0; bit_q <= 4'h0;
      idx_q <= 2'h0; rd_q <= 1'b0; scl_low_q <= 1'b0; sda_low_q <= 1'b0;
      nack_q <= 1'b0; done_q <= 1'b0; reg_q <= 8'h00; wd_q <= 8'h00;
      sh_q <= 8'h00; rdata_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      div_q  <= tick ? 16'(QTR_CYC - 1) : div_q - 16'h0001;
      if (st_q == M_IDLE) begin
        qtr_q <= 2'h0;
        if (cmd_valid_i && cmd_ready_o) begin
          rd_q <= cmd_read_i; reg_q <= cmd_reg_i; wd_q <= cmd_wdata_i;
          idx_q <= 2'h0; nack_q <= 1'b0; st_q <= M_START;
          div_q <= 16'(QTR_CYC - 1);
        end
      end else if (tick) begin
        qtr_q <= qtr_q + 2'h1;
        case (st_q)
          M_START: begin
            // [R16] Also serves as repeated start
            case (qtr_q)
              2'h0: sda_low_q <= 1'b0;
              2'h1: scl_low_q <= 1'b0;
              2'h2: sda_low_q <= 1'b1;
              default: begin
                scl_low_q <= 1'b1; bit_q <= 4'h0; st_q <= M_BIT;
              end
            endcase
          end
          M_BIT: begin
            case (qtr_q)
              // [R2] Data set while clock low
              // [R17] Ninth bit released on read: nack
              2'h0: sda_low_q <= bit_data && !rx_mode && !tx_bit;
              2'h1: scl_low_q <= 1'b0;
              2'h2: begin
                if (bit_data && rx_mode) sh_q <= {sh_q[6:0], sda_s};
                // [R7] Target ack sampled on ninth
                if (!bit_data && !rx_mode && sda_s) nack_q <= 1'b1;
              end
              default: begin
                scl_low_q <= 1'b1;
                if (bit_data) begin
                  bit_q <= bit_q + 4'h1;
                end else if (nack_q || last_byte) begin
                  if (rx_mode) rdata_q <= sh_q;
                  st_q <= M_STOP;
                end else if (rd_q && idx_q == 2'h1) begin
                  idx_q <= 2'h2; st_q <= M_START;
                end else begin
                  idx_q <= idx_q + 2'h1; bit_q <= 4'h0;
                end
              end
            endcase
          end
          M_STOP: begin
            case (qtr_q)
              2'h0: sda_low_q <= 1'b1;
              2'h1: scl_low_q <= 1'b0;
              2'h2: sda_low_q <= 1'b0;
              default: begin
                done_q <= 1'b1; st_q <= M_IDLE;
              end
            endcase
          end
          default: st_q <= M_IDLE;
        endcase
      end
    end
  end

  // [R20] Open-drain drives
  assign bus.scl_o      = 1'b0;
  assign bus.scl_oe_n   = ~scl_low_q;
  assign bus.sda_h_o    = 1'b0;
  assign bus.sda_h_oe_n = ~sda_low_q;
  assign done_o         = done_q;
  assign nack_o         = nack_q;
  assign rdata_o        = rdata_q;
endmodule : srp_host

// ### dv/srp_props.sv
// Concurrent checks on the two-wire link that joins the host and target ends.
// Assumes the interface signals as plain inputs, sampled on the host clock.
`timescale 1ns/1ns
module srp_props #(
  parameter int QTR_CYC = 6
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_h_o,
  input wire logic sda_h_oe_n,
  input wire logic sda_t_o,
  input wire logic sda_t_oe_n,
  input wire logic scl,
  input wire logic sda
);
  // -------------------------------------------------------------
  // Line history and bit counting
  // -------------------------------------------------------------
  localparam int MAX_LOW = 9 * 4 * QTR_CYC + 8;
  logic       scl_q, sda_q, seen_q;
  logic [3:0] rise_q, rise_d;
  int         low_q;
  wire        start_w = scl & scl_q & sda_q & ~sda;
  wire        stop_w  = scl & scl_q & ~sda_q & sda;
  wire        rise_w  = scl & ~scl_q;
  assign rise_d = start_w ? 4'h0 : (rise_w && rise_q != 4'hF) ? rise_q + 4'h1 : rise_q;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      seen_q <= 1'b0;
      rise_q <= 4'h0;
      low_q  <= 0;
    end else begin
      scl_q  <= scl;
      sda_q  <= sda;
      seen_q <= seen_q | start_w;
      rise_q <= rise_d;
      low_q  <= sda_t_oe_n ? 0 : low_q + 1;
    end
  end

  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_drive_zero; !scl_o && !sda_h_o && !sda_t_o; endproperty
  a_drive_zero: assert property (p_drive_zero)
    else $error("a drive value is not zero");
  property p_tgt_steady; scl && $past(scl) |-> $stable(sda_t_oe_n); endproperty
  a_tgt_steady: assert property (p_tgt_steady)
    else $error("target data drive changed while clock high");
  property p_sda_host; scl && $past(scl) && $changed(sda) |-> $changed(sda_h_oe_n); endproperty
  a_sda_host: assert property (p_sda_host)
    else $error("data changed while clock high without host");
  property p_quiet; !seen_q |-> sda_t_oe_n; endproperty
  a_quiet: assert property (p_quiet)
    else $error("target drove before any start");
  property p_stop_rel; stop_w |=> sda_t_oe_n [*8]; endproperty
  a_stop_rel: assert property (p_stop_rel)
    else $error("target drove right after stop");
  property p_first_ack; rise_w && !sda_t_oe_n && rise_q < 4'h9 |-> rise_q == 4'h8; endproperty
  a_first_ack: assert property (p_first_ack)
    else $error("target drove outside the address ack slot");
  property p_host_rel; rise_w && rise_q == 4'h8 |-> sda_h_oe_n; endproperty
  a_host_rel: assert property (p_host_rel)
    else $error("host held data during address ack slot");
  property p_low_bound; low_q <= MAX_LOW; endproperty
  a_low_bound: assert property (p_low_bound)
    else $error("target held data low too long");

  c_ack: cover property (rise_w && rise_q == 4'h8 && !sda);
  c_restart: cover property (start_w && rise_q != 4'h0);
  c_stop: cover property (stop_w);
endmodule : srp_props

// ### dv/test_sensor_i2c_slave_regport.sv
// Bench: host and target joined on one link, and a second target
// driven bit by bit for bursts, bad addresses and early stops.
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
module test_sensor_i2c_slave_regport;
  import srp_pkg::*;
  localparam int QTR = 6;
  localparam int BBQ = 8;
  logic      ref_clk = 1'b0, link_clk = 1'b0, nrst = 1'b0;
  logic      cmd_valid = 1'b0, cmd_read = 1'b0, cmd_ready, done, nack, we1, we2, a;
  srp_byte_t cmd_reg = 8'h00, cmd_wdata = 8'h00;
  srp_byte_t rdata, ptr1, ptr2, wa1, wa2, wd1, wd2, g, r, d;
  srp_byte_t regs [2][11];
  srp_byte_t bd [3];
  int        error_cnt = 0, checks_done = 0;
  srp_i2c_if bus1 ();
  srp_i2c_if bus2 ();
  wire srp_byte_t rd1 = (ptr1 <= 8'h0A) ? regs[0][ptr1] : 8'h00;
  wire srp_byte_t rd2 = (ptr2 <= 8'h0A) ? regs[1][ptr2] : 8'h00;

  always #5 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end

  // Register arrays behind both targets
  always @(posedge link_clk or negedge nrst) begin
    if (!nrst) regs <= '{default: 8'h00};
    else begin
      if (we1) regs[0][wa1] <= wd1;
      if (we2) regs[1][wa2] <= wd2;
    end
  end

  srp_host #(.QTR_CYC(QTR)) i_srp_host (.ref_clk_i(ref_clk), .nrst_i(nrst), .bus(bus1),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read),
    .cmd_reg_i(cmd_reg), .cmd_wdata_i(cmd_wdata), .done_o(done), .nack_o(nack),
    .rdata_o(rdata));
  srp_target #(.POWERUP_CYC(200)) i_srp_target (.link_clk_i(link_clk), .nrst_i(nrst),
    .bus(bus1), .reg_ptr_o(ptr1), .reg_rdata_i(rd1), .reg_we_o(we1), .reg_waddr_o(wa1),
    .reg_wdata_o(wd1), .busy_o());
  srp_target #(.POWERUP_CYC(200)) i_srp_target_2 (.link_clk_i(link_clk), .nrst_i(nrst),
    .bus(bus2), .reg_ptr_o(ptr2), .reg_rdata_i(rd2), .reg_we_o(we2), .reg_waddr_o(wa2),
    .reg_wdata_o(wd2), .busy_o());
  srp_props #(.QTR_CYC(QTR)) i_srp_props (.ref_clk_i(ref_clk), .nrst_i(nrst),
    .scl_o(bus1.scl_o), .scl_oe_n(bus1.scl_oe_n), .sda_h_o(bus1.sda_h_o),
    .sda_h_oe_n(bus1.sda_h_oe_n), .sda_t_o(bus1.sda_t_o), .sda_t_oe_n(bus1.sda_t_oe_n),
    .scl(bus1.scl), .sda(bus1.sda));

  function automatic srp_byte_t nxt(input srp_byte_t p);
    return (p == 8'h0A) ? 8'h00 : p + 8'h01;
  endfunction : nxt

  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic host_op(input logic rd, input srp_byte_t ra, input srp_byte_t wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    cmd_read <= rd;
    cmd_reg <= ra;
    cmd_wdata <= wd;
    cmd_valid <= 1'b1;
    do @(negedge ref_clk); while (cmd_ready !== 1'b1 && ++n < 20000);
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    do @(negedge ref_clk); while (done !== 1'b1 && ++n < 20000);
    if (n >= 20000) begin
      error_cnt++;
      $display("ERROR %0t: host command hung", $time);
    end
  endtask : host_op

  // One quarter bit on the second link
  task automatic bbq(input logic c, input logic s);
    @(posedge ref_clk);
    bus2.scl_oe_n <= c;
    bus2.sda_h_oe_n <= s;
    repeat (BBQ - 1) @(posedge ref_clk);
  endtask : bbq

  task automatic bb_start();
    bbq(1'b0, 1'b1);
    bbq(1'b1, 1'b1);
    bbq(1'b1, 1'b0);
    bbq(1'b0, 1'b0);
  endtask : bb_start

  task automatic bb_stop();
    bbq(1'b0, 1'b0);
    bbq(1'b1, 1'b0);
    bbq(1'b1, 1'b1);
  endtask : bb_stop

  // First nb of eight data bits then the ack bit, most significant first
  task automatic bb_byte(input logic [8:0] v, input int nb);
    for (int i = 8; i > 8 - nb; i--) begin
      bbq(1'b0, v[i]);
      bbq(1'b1, v[i]);
      if (i > 0) g[i - 1] = bus2.sda;
      else a = ~bus2.sda;
      bbq(1'b1, v[i]);
      bbq(1'b0, v[i]);
    end
  endtask : bb_byte

  initial begin
    #800000;
    error_cnt++;
    $display("ERROR %0t: watchdog expired", $time);
    complete_run();
  end

  initial begin
    void'($urandom(52));
    bus2.scl_o = 1'b0;
    bus2.sda_h_o = 1'b0;
    bus2.scl_oe_n = 1'b1;
    bus2.sda_h_oe_n = 1'b1;
    // Targets reset on the link clock: hold across two of its edges
    repeat (2) @(posedge link_clk);
    @(posedge ref_clk);
    nrst <= 1'b1;
    host_op(1'b0, 8'h03, 8'h5A);
    `CHK(nack, 1'b1)
    `CHK(regs[0][3], 8'h00)
    repeat (700) @(posedge ref_clk);
    for (int k = 0; k < 4; k++) begin
      r = (k == 0) ? 8'h0A : 8'($urandom_range(10));
      d = 8'($urandom);
      host_op(1'b0, r, d);
      `CHK(nack, 1'b0)
      repeat (150) @(posedge ref_clk);
      `CHK(regs[0][r], d)
      `CHK(ptr1, r)
      host_op(1'b1, r, 8'h00);
      `CHK(rdata, d)
      `CHK(ptr1, nxt(r))
    end
    host_op(1'b0, r, ~d);
    host_op(1'b1, r, 8'h00);
    `CHK(nack, 1'b1)
    repeat (150) @(posedge ref_clk);
    host_op(1'b1, r, 8'h00);
    `CHK(rdata, ~d)
    bb_start();
    bb_byte({8'h88, 1'b1}, 9);
    `CHK(a, 1'b1)
    bb_byte({8'h03, 1'b1}, 9);
    `CHK(a, 1'b1)
    // Complete byte pending, then stop mid-byte
    bb_byte({8'h5A, 1'b1}, 9);
    bb_byte({8'hFF, 1'b1}, 4);
    bb_stop();
    repeat (100) @(posedge ref_clk);
    `CHK(regs[1][3], 8'h00)
    bb_start();
    bb_byte({8'h8A, 1'b1}, 9);
    `CHK(a, 1'b0)
    bb_stop();
    foreach (bd[j]) bd[j] = 8'($urandom);
    bb_start();
    bb_byte({8'h88, 1'b1}, 9);
    bb_byte({8'h09, 1'b1}, 9);
    for (int j = 0; j < 3; j++) begin
      bb_byte({bd[j], 1'b1}, 9);
      `CHK(a, 1'b1)
    end
    bb_stop();
    repeat (150) @(posedge ref_clk);
    for (int j = 0; j < 3; j++) `CHK(regs[1][(9 + j) % 11], bd[j])
    `CHK(ptr2, 8'h00)
    bb_start();
    bb_byte({8'h88, 1'b1}, 9);
    bb_byte({8'h09, 1'b1}, 9);
    bb_start();
    bb_byte({8'h89, 1'b1}, 9);
    `CHK(a, 1'b1)
    for (int j = 0; j < 3; j++) begin
      // Ack all but the last byte
      bb_byte({8'hFF, j == 2}, 9);
      `CHK(g, bd[j])
    end
    bb_stop();
    `CHK(ptr2, 8'h01)
    complete_run();
  end
endmodule : test_sensor_i2c_slave_regport
